// File: lmzs_defs.vh
`ifndef LMZS_DEFS_VH
`define LMZS_DEFS_VH
// timing figures in ns, converted to cycles of the 5 ns reference clock
`define LMZS_CLK_PS        5000
`define LMZS_TMRW_NS       10
`define LMZS_TINIT4_NS     1000
`define LMZS_TZQINIT_NS    1000000
`define LMZS_TZQRESET_NS   50
`define LMZS_TZQCL_NS      360
`define LMZS_TZQCS_NS      90
`define LMZS_TXP_NS        8
// mode register addresses and data selecting the special writes (values arbitrary, set per part)
`define LMZS_MA_RESET      8'h3f
`define LMZS_MA_ZQ         8'h0a
`define LMZS_OP_ZQINIT     8'hff
`define LMZS_OP_ZQCL       8'hab
`define LMZS_OP_ZQCS       8'h56
`define LMZS_OP_ZQRESET    8'hc3
// zq calibration kinds
`define LMZS_ZQ_INIT       2'h0
`define LMZS_ZQ_RESET      2'h1
`define LMZS_ZQ_LONG       2'h2
`define LMZS_ZQ_SHORT      2'h3
`endif

// File: lmzs_cnt.v
`timescale 1ns/1ps
`default_nettype none
// loadable down counter; done pulses on the last count of one, the cycle before it reads zero
module lmzs_cnt #(
  parameter W = 20
) (
  input  wire         i_ref_clk, // clock
  input  wire         i_nrst,    // async reset, low
  input  wire         i_load,    // load pulse
  input  wire [W-1:0] i_val,     // cycles to run
  output wire         o_busy,    // counting
  output wire         o_done     // one-cycle end pulse
);
  reg [W-1:0] cnt_q;
  // count down to zero after each load
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      cnt_q <= {W{1'b0}};
    else if (i_load)
      cnt_q <= i_val;
    else if (cnt_q != {W{1'b0}})
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
  end
  assign o_busy = (cnt_q != {W{1'b0}});
  assign o_done = (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !i_load;
endmodule // lmzs_cnt
`default_nettype wire

// File: lmzs_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "lmzs_defs.vh"
// Functional notes
// - mode register read allowed idle or active; bank state kept
// - reset write from idle enters auto-init, mode registers to default
// - array undefined after reset; boot timing until idle again
// - four zq kinds started by write: init, reset, long, short, own periods
// - zq pin current path off once calibration completes
// - zq tied high: ignore calibration commands, keep defaults
// - power down entry: cke low, cs high, cke high previous edge
// - in power down only clock and cke buffers stay on
// - no refresh during power down; controller exits in time
// - write decoded cs low, ca0-3 low; address from both edges, data from the falling edge only
module lmzs_seq #(
  parameter CW = 20 // counter width
) (
  input  wire        i_ref_clk,    // clock
  input  wire        i_nrst,       // async reset, low
  input  wire        i_cke,        // clock enable pin
  input  wire        i_cs_n,       // chip select pin, low active
  input  wire [9:0]  i_ca_rise,    // ca bus, rising edge half
  input  wire [9:0]  i_ca_fall,    // ca bus, falling edge half
  input  wire        i_banks_act,  // some bank active
  input  wire        i_zq_tied,    // zq strapped to vddca
  output reg         o_mr_we,      // mode register write strobe
  output reg  [7:0]  o_mr_addr,    // mode register address
  output reg  [7:0]  o_mr_data,    // mode register data
  output reg         o_mr_default, // restore all mode registers pulse
  output reg         o_array_bad,  // array contents undefined
  output reg         o_busy,       // nop-only period running
  output reg         o_pd,         // in power down
  output reg         o_buf_en,     // non-clock input/output buffers on
  output reg         o_zq_on,      // zq current path on
  output reg         o_zq_quiet,   // data bus must stay quiet
  output reg  [1:0]  o_zq_kind,    // active calibration kind
  output reg         o_cmd_ok,     // executable commands accepted
  output reg  [2:0]  o_state       // sequencer state
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_MRW  = 3'h1;
  localparam [2:0] S_RST  = 3'h2;
  localparam [2:0] S_ZQ   = 3'h3;
  localparam [2:0] S_PD   = 3'h4;
  localparam [2:0] S_XP   = 3'h5;

  // ns to cycles, rounded up (least times)
  function [CW-1:0] cyc;
    input integer ns;
    integer c;
    begin
      c = (ns * 1000 + `LMZS_CLK_PS - 1) / `LMZS_CLK_PS;
      if (c < 1)
        c = 1;
      cyc = c[CW-1:0];
    end
  endfunction

  localparam [CW-1:0] C_MRW  = cyc(`LMZS_TMRW_NS);
  localparam [CW-1:0] C_INIT = cyc(`LMZS_TINIT4_NS);
  localparam [CW-1:0] C_ZQI  = cyc(`LMZS_TZQINIT_NS);
  localparam [CW-1:0] C_ZQR  = cyc(`LMZS_TZQRESET_NS);
  localparam [CW-1:0] C_ZQL  = cyc(`LMZS_TZQCL_NS);
  localparam [CW-1:0] C_ZQS  = cyc(`LMZS_TZQCS_NS);
  localparam [CW-1:0] C_XP   = cyc(`LMZS_TXP_NS);

  // pins come from the controller's domain: two flops before use
  reg        cke_m_q, cke_q, cs_m_q, cs_q;
  reg [9:0]  car_m_q, car_q, caf_m_q, caf_q;
  reg        ba_m_q, ba_q, zt_m_q, zt_q;
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cke_m_q <= 1'b0;
      cke_q   <= 1'b0;
      cs_m_q  <= 1'b1;
      cs_q    <= 1'b1;
      car_m_q <= 10'h3ff;
      car_q   <= 10'h3ff;
      caf_m_q <= 10'h000;
      caf_q   <= 10'h000;
      ba_m_q  <= 1'b0;
      ba_q    <= 1'b0;
      zt_m_q  <= 1'b0;
      zt_q    <= 1'b0;
    end else begin
      cke_m_q <= i_cke;
      cke_q   <= cke_m_q;
      cs_m_q  <= i_cs_n;
      cs_q    <= cs_m_q;
      car_m_q <= i_ca_rise;
      car_q   <= car_m_q;
      caf_m_q <= i_ca_fall;
      caf_q   <= caf_m_q;
      ba_m_q  <= i_banks_act;
      ba_q    <= ba_m_q;
      zt_m_q  <= i_zq_tied;
      zt_q    <= zt_m_q;
    end
  end

  // previous sampled cke for entry detection
  reg cke_p_q;
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      cke_p_q <= 1'b0;
    else
      cke_p_q <= cke_q;
  end

  // command decode
  wire       mrw_hit = cke_q && cke_p_q && !cs_q && (car_q[3:0] == 4'h0);
  wire [7:0] ma      = {caf_q[1:0], car_q[9:4]};
  wire [7:0] op      = caf_q[9:2];
  wire       is_rst  = (ma == `LMZS_MA_RESET);
  wire       is_zq   = (ma == `LMZS_MA_ZQ) && ((op == `LMZS_OP_ZQINIT) ||
                       (op == `LMZS_OP_ZQCL) || (op == `LMZS_OP_ZQCS) ||
                       (op == `LMZS_OP_ZQRESET));
  wire       pd_hit  = !cke_q && cke_p_q && cs_q;
  wire       mrw_ok  = mrw_hit && !ba_q;

  reg  [2:0]    st_q, st_d;
  reg  [1:0]    kind_q, kind_d;
  reg           ld;
  reg  [CW-1:0] ld_val;
  wire          t_busy, t_done;

  lmzs_cnt #(.W(CW)) u_tmr (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_load    (ld),
    .i_val     (ld_val),
    .o_busy    (t_busy),
    .o_done    (t_done)
  );

  // next-state logic
  always @* begin
    st_d   = st_q;
    kind_d = kind_q;
    ld     = 1'b0;
    ld_val = C_MRW;
    case (st_q)
      S_IDLE: begin
        if (pd_hit) begin
          st_d = S_PD;
        end else if (mrw_ok && is_rst) begin
          st_d = S_RST;
          ld = 1'b1;
          ld_val = C_INIT;
        end else if (mrw_ok && is_zq && !zt_q) begin
          st_d = S_ZQ;
          ld = 1'b1;
          if (op == `LMZS_OP_ZQINIT) begin
            kind_d = `LMZS_ZQ_INIT;
            ld_val = C_ZQI;
          end else if (op == `LMZS_OP_ZQRESET) begin
            kind_d = `LMZS_ZQ_RESET;
            ld_val = C_ZQR;
          end else if (op == `LMZS_OP_ZQCL) begin
            kind_d = `LMZS_ZQ_LONG;
            ld_val = C_ZQL;
          end else begin
            kind_d = `LMZS_ZQ_SHORT;
            ld_val = C_ZQS;
          end
        end else if (mrw_ok) begin
          st_d = S_MRW;
          ld = 1'b1;
          ld_val = C_MRW;
        end
      end
      S_MRW, S_RST, S_ZQ: begin
        if (t_done)
          st_d = S_IDLE;
      end
      S_PD: begin
        if (cke_q) begin
          st_d = S_XP;
          ld = 1'b1;
          ld_val = C_XP;
        end
      end
      S_XP: begin
        if (t_done || !t_busy)
          st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // state registers
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q   <= S_IDLE;
      kind_q <= `LMZS_ZQ_INIT;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
    end
  end

  // registered outputs; mrr needs no state change, banks untouched
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mr_we      <= 1'b0;
      o_mr_addr    <= 8'h00;
      o_mr_data    <= 8'h00;
      o_mr_default <= 1'b0;
      o_array_bad  <= 1'b1;
      o_busy       <= 1'b0;
      o_pd         <= 1'b0;
      o_buf_en     <= 1'b1;
      o_zq_on      <= 1'b0;
      o_zq_quiet   <= 1'b0;
      o_zq_kind    <= `LMZS_ZQ_INIT;
      o_cmd_ok     <= 1'b1;
      o_state      <= S_IDLE;
    end else begin
      o_mr_we      <= (st_q == S_IDLE) && mrw_ok && !is_rst && !is_zq;
      o_mr_addr    <= (st_q == S_IDLE && mrw_ok) ? ma : o_mr_addr;
      o_mr_data    <= (st_q == S_IDLE && mrw_ok) ? op : o_mr_data;
      o_mr_default <= (st_d == S_RST) && (st_q == S_IDLE);
      // array marked undefined by reset write; cleared by the next ordinary write (not a zq or reset write)
      if ((st_d == S_RST) && (st_q == S_IDLE))
        o_array_bad <= 1'b1;
      else if (o_mr_we)
        o_array_bad <= 1'b0;
      o_busy       <= (st_d == S_MRW) || (st_d == S_RST) || (st_d == S_ZQ);
      o_pd         <= (st_d == S_PD);
      o_buf_en     <= (st_d != S_PD);
      o_zq_on      <= (st_d == S_ZQ);
      o_zq_quiet   <= (st_d == S_ZQ) && (kind_d != `LMZS_ZQ_RESET);
      o_zq_kind    <= kind_d;
      o_cmd_ok     <= (st_d == S_IDLE);
      o_state      <= st_d;
    end
  end
endmodule // lmzs_seq
`default_nettype wire

// File: lmzs_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// pin events reach the outputs three edges later (two sync flops plus output register)
module lmzs_seq_assertions (
  input wire logic       i_ref_clk,    // clock
  input wire logic       i_nrst,       // reset, low
  input wire logic       i_cke,        // cke pin
  input wire logic       i_cs_n,       // chip select pin
  input wire logic       i_banks_act,  // bank active
  input wire logic       i_zq_tied,    // zq strapped
  input wire logic       o_mr_we,      // write strobe
  input wire logic       o_mr_default, // defaults pulse
  input wire logic       o_array_bad,  // array undefined
  input wire logic       o_busy,       // nop-only period
  input wire logic       o_pd,         // power down
  input wire logic       o_buf_en,     // buffers on
  input wire logic       o_zq_on,      // zq path on
  input wire logic       o_zq_quiet,   // data bus quiet
  input wire logic [1:0] o_zq_kind,    // calibration kind
  input wire logic       o_cmd_ok,     // commands accepted
  input wire logic [2:0] o_state       // sequencer state
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_pd_buf_off: assert property (o_pd |-> !o_buf_en && !o_cmd_ok)
    else $error("buffers on in power down");
  a_mrw_period: assert property ($rose(o_mr_we) |-> o_busy [*2] ##1 !o_busy)
    else $error("write period length wrong");
  a_mrw_idle_only: assert property ($rose(o_mr_we) |-> !$past(i_banks_act, 3))
    else $error("write taken with bank active");
  a_reset_init: assert property (o_mr_default |-> o_array_bad && o_state == 3'h2)
    else $error("reset write without init state");
  a_zq_quiet: assert property (o_zq_quiet |-> o_zq_on && o_zq_kind != 2'h1)
    else $error("quiet bus during zq reset");
  a_zq_pin_off: assert property (o_zq_on |-> o_state == 3'h3 && o_busy)
    else $error("zq path on outside calibration");
  a_zq_tied: assert property (i_zq_tied && $past(i_zq_tied, 3) |-> !o_zq_on)
    else $error("calibration run with zq tied");
  a_pd_entry: assert property ($rose(o_pd) |-> $past(i_cke, 4) && !$past(i_cke, 3) && $past(i_cs_n, 3))
    else $error("power down entered without cke fall");
  a_exit_wait: assert property ($fell(o_pd) |-> !o_cmd_ok ##[1:3] o_cmd_ok)
    else $error("exit latency wrong");
endmodule // lmzs_seq_assertions
bind lmzs_seq lmzs_seq_assertions chk (.*);
`default_nettype wire

// File: lmzs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: drives pins 1 ns after the edge, idle ca toggles so stale bits never look valid
module lmzs_ctrl_model (
  input  wire logic       i_ref_clk, // clock
  input  wire logic       i_ready,   // device accepts commands
  output logic            o_cke,     // clock enable
  output logic            o_cs_n,    // chip select, low
  output logic [9:0]      o_ca_rise, // ca rising half
  output logic [9:0]      o_ca_fall  // ca falling half
);
  initial begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_ca_rise = 10'h3ff;
    o_ca_fall = 10'h000;
  end
  // deselected cycles only; cke left as is
  task automatic nop(input int n);
    repeat (n) begin
      @(posedge i_ref_clk) #1;
      o_cs_n = 1'b1;
      o_ca_rise = ~o_ca_rise;
      o_ca_fall = ~o_ca_fall;
    end
  endtask
  // waits up to 400 cycles for a running period to end, then one write and enough nops for the answer
  // a single device sits on the resistor, so its calibration periods never overlap another's
  task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
    int k;
    k = 0;
    while (i_ready !== 1'b1 && k < 400) begin
      nop(1);
      k++;
    end
    @(posedge i_ref_clk) #1;
    o_cs_n = 1'b0;
    o_ca_rise = {ma[5:0], 4'h0};
    o_ca_fall = {op, ma[7:6]};
    nop(4);
  endtask
  // power down for n cycles; only called when idle so no operation is cut
  task automatic pd(input int n);
    @(posedge i_ref_clk) #1;
    o_cke = 1'b0;
    o_cs_n = 1'b1;
    nop(n);
    o_cke = 1'b1;
    nop(2);
  endtask
endmodule // lmzs_ctrl_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
  logic       i_ref_clk, i_nrst, i_banks_act, i_zq_tied;
  wire        i_cke, i_cs_n;
  wire  [9:0] i_ca_rise, i_ca_fall;
  wire        o_mr_we, o_mr_default, o_array_bad, o_busy, o_pd, o_buf_en, o_zq_on, o_zq_quiet, o_cmd_ok;
  wire  [7:0] o_mr_addr, o_mr_data;
  wire  [1:0] o_zq_kind;
  wire  [2:0] o_state;
  int         fails, checks, cyc, n_we, n_def, n_busy, n_pd, n_off, n_on, n_quiet;
  logic [1:0] kind_seen;
  lmzs_seq uut (.*);
  lmzs_ctrl_model ctl (.i_ref_clk, .i_ready(o_cmd_ok), .o_cke(i_cke), .o_cs_n(i_cs_n),
    .o_ca_rise(i_ca_rise), .o_ca_fall(i_ca_fall));
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // counts what the outputs did; the run is cut if it hangs
  always @(posedge i_ref_clk) begin
    cyc++;
    n_we += (o_mr_we === 1'b1);
    n_def += (o_mr_default === 1'b1);
    n_busy += (o_busy === 1'b1);
    n_pd += (o_pd === 1'b1);
    n_off += (o_buf_en === 1'b0);
    n_quiet += (o_zq_quiet === 1'b1);
    n_on += (o_zq_on === 1'b1);
    if (o_zq_on === 1'b1) kind_seen = o_zq_kind;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task clr;
    {n_we, n_def, n_busy, n_pd, n_off, n_on, n_quiet} = '0;
  endtask
  // waits for the design to reach idle, bounded
  task settle;
    int k;
    k = 0;
    repeat (4) @(posedge i_ref_clk);
    while (o_cmd_ok !== 1'b1 && k < 400) begin
      @(posedge i_ref_clk);
      k++;
    end
    #1;
    `CHK(o_cmd_ok, 1'b1)
    `CHK(o_state, 3'h0)
  endtask
  task go(input logic [7:0] ma, input logic [7:0] op);
    clr();
    ctl.mrw(ma, op);
    settle();
  endtask
  task s_reset;
    go(8'h3f, 8'h00);
    `CHK(n_def, 1)
    `CHK(n_busy, 200)
    `CHK(o_array_bad, 1'b1)
  endtask
  task s_mrw;
    go(8'h25, 8'h96);
    `CHK(n_we, 1)
    `CHK(o_mr_addr, 8'h25)
    `CHK(o_mr_data, 8'h96)
    `CHK(n_busy, 2)
    `CHK(o_array_bad, 1'b0)
  endtask
  // a write with a bank open must leave no trace
  task s_banks;
    i_banks_act = 1'b1;
    go(8'h25, 8'h11);
    `CHK(n_we, 0)
    `CHK(o_mr_data, 8'h96)
    i_banks_act = 1'b0;
  endtask
  // init calibration left out: its period alone would exceed the run budget
  task s_zq(input logic [7:0] op, input logic [1:0] kind, input int len, input logic quiet);
    go(8'h0a, op);
    `CHK(n_busy, len)
    `CHK(kind_seen, kind)
    `CHK((n_quiet != 0), quiet)
    `CHK(o_zq_on, 1'b0)
  endtask
  task s_tied;
    i_zq_tied = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    go(8'h0a, 8'hab);
    `CHK(n_we, 0)
    `CHK(n_on, 0)
    `CHK(n_busy, 2)
    i_zq_tied = 1'b0;
  endtask
  task s_pd;
    clr();
    ctl.pd(6);
    settle();
    `CHK(n_pd, 6)
    `CHK(n_off, 6)
    go(8'h25, 8'h3c);
    `CHK(n_we, 1)
  endtask
  // init calibration is far too long to finish here: start it, look at it, then cut it with a reset
  task s_zqinit;
    clr();
    ctl.mrw(8'h0a, 8'hff);
    `CHK(o_zq_kind, 2'h0)
    `CHK(o_zq_quiet, 1'b1)
    repeat (100) @(posedge i_ref_clk);
    #1;
    `CHK(o_busy, 1'b1)
    `CHK(o_zq_on, 1'b1)
    i_nrst = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 i_nrst = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #1;
    `CHK(o_zq_on, 1'b0)
    `CHK(o_array_bad, 1'b1)
    `CHK(o_state, 3'h0)
  endtask
  initial begin
    {fails, checks, cyc} = '0;
    i_nrst = 1'b0;
    i_banks_act = 1'b0;
    i_zq_tied = 1'b0;
    clr();
    repeat (3) @(posedge i_ref_clk);
    #1 i_nrst = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    s_reset();
    s_mrw();
    s_banks();
    s_zq(8'hc3, 2'h1, 10, 1'b0);
    s_zq(8'hab, 2'h2, 72, 1'b1);
    s_zq(8'h56, 2'h3, 18, 1'b1);
    s_tied();
    s_pd();
    s_zqinit();
    results();
  end
endmodule // testbench
`default_nettype wire
